// *** fpp_pkg.sv ***
// Overview of operation
// - port B error flag goes low when any valid lane fails parity
// - a port B lane is checked only if the active bus size uses it
// - port B check polarity follows the odd/even select input
// - port B error flag forced high while a mail-in read with generation is set up
// - port A generation inserts parity into the top bit of each mail-out lane
// - port B generation inserts parity into the top bit of each read lane
// - generated parity polarity on both ports follows the odd/even select
// - reset holds almost-full and mail flags high, empty, almost-empty, full low
// - offset preset selects are captured when reset is released
// - size and endian pins are captured on one port B edge, applied on the next
// - long word, word and byte sizes; both selects high chooses the mailbox
// - swap mode is sampled at the start of each long word FIFO read
// - port A write/read select chooses the access; outputs off while writing
// - port B write/read select chooses the access; outputs off while writing
// - odd parity when the polarity select is high, even when low
// - narrow FIFO reads use the high lanes when endian is low, else low lanes
// - port B mailbox read sets the mail-in flag high
package fpp_pkg;
    localparam int          FPP_W           = 36;
    localparam int          FPP_LANES       = 4;
    localparam int          FPP_LANE_W      = 9;
    localparam int          FPP_EV_W        = 4;
    localparam int          FPP_PIN_W       = 91;
    // register byte offsets
    localparam logic [7:0]  FPP_STATUS_OFS  = 8'h00;
    localparam logic [7:0]  FPP_MASK_OFS    = 8'h04;
    localparam logic [7:0]  FPP_CTRL_OFS    = 8'h08;
    localparam logic [7:0]  FPP_STATE_OFS   = 8'h0C;
    // status / mask / control bit positions
    localparam int          FPP_EV_PE_B     = 0;
    localparam int          FPP_EV_PE_A     = 1;
    localparam int          FPP_EV_MAIL_IN  = 2;
    localparam int          FPP_EV_MAIL_OUT = 3;
    localparam int          FPP_CTRL_PAR_EN = 0;
    // reset values and counts
    localparam logic [3:0]  FPP_MASK_RST    = 4'h0;
    localparam logic        FPP_CTRL_RST    = 1'b1;
    localparam logic [1:0]  FPP_FULL_EDGES  = 2'h2;
    localparam logic [1:0]  FPP_CAPTURE_CNT = 2'h2;
    localparam logic [1:0]  FPP_CAPTURE_END = 2'h3;

    typedef enum logic [1:0] {
        FPP_SIZE_LONG = 2'b00,
        FPP_SIZE_WORD = 2'b01,
        FPP_SIZE_BYTE = 2'b10,
        FPP_SIZE_MAIL = 2'b11
    } fpp_size_type;

    typedef enum logic [1:0] {
        FPP_SWAP_NONE  = 2'b00,
        FPP_SWAP_BYTE  = 2'b01,
        FPP_SWAP_WORD  = 2'b10,
        FPP_SWAP_BWORD = 2'b11
    } fpp_swap_type;

    // replaces the top bit of each lane with generated parity
    function automatic logic [35:0] fpp_fill_parity(input logic [35:0] w, input logic odd);
        logic [35:0] r;
        r = w;
        for (int i = 0; i < FPP_LANES; i++) begin
            r[i*FPP_LANE_W+8] = (^w[i*FPP_LANE_W +: 8]) ^ odd;
        end
        return r;
    endfunction : fpp_fill_parity
endpackage : fpp_pkg

// *** fpp_parity_tree.sv ***
`timescale 1ns/10ps
// per-lane parity check of one 36-bit bus
module fpp_parity_tree
    import fpp_pkg::*;
(
    input  wire logic [35:0] data,
    input  wire logic        odd,
    output logic      [3:0]  lane_fail
);
    // a lane fails when its nine-bit xor differs from the polarity
    genvar g;
    generate
        for (g = 0; g < FPP_LANES; g++) begin : g_lane
            assign lane_fail[g] = (^data[g*FPP_LANE_W +: FPP_LANE_W]) != odd;
        end
    endgenerate
endmodule : fpp_parity_tree

// *** fpp_port_ctrl.sv ***
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module fpp_port_ctrl
    import fpp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        port_a_clock,
    input  wire logic        port_a_select_n,
    input  wire logic        port_a_enable,
    input  wire logic        port_a_write_not_read,
    input  wire logic        port_a_mailbox_sel,
    input  wire logic        port_a_parity_gen,
    input  wire logic [35:0] port_a_data_in,
    output logic      [35:0] port_a_data_out,
    output logic             port_a_data_oe,
    input  wire logic        port_b_clock,
    input  wire logic        port_b_select_n,
    input  wire logic        port_b_enable,
    input  wire logic        port_b_write_not_read,
    input  wire logic        port_b_parity_gen,
    input  wire logic        bus_size_sel0,
    input  wire logic        bus_size_sel1,
    input  wire logic        endian_select_n,
    input  wire logic        swap_sel0,
    input  wire logic        swap_sel1,
    input  wire logic [35:0] port_b_data_in,
    output logic      [35:0] port_b_data_out,
    output logic             port_b_data_oe,
    input  wire logic        odd_even_sel,
    input  wire logic        offset_preset_sel0,
    input  wire logic        offset_preset_sel1,
    input  wire logic [35:0] fifo_word,
    output logic             fifo_word_taken,
    output logic             port_a_parity_error_n,
    output logic             port_b_parity_error_n,
    output logic             almost_full_n,
    output logic             almost_empty_n,
    output logic             empty_flag_n,
    output logic             full_flag_n,
    output logic             mail_in_full_n,
    output logic             mail_out_full_n,
    output logic      [1:0]  offset_preset
);
    logic [FPP_PIN_W-1:0] pins_w;
    logic [FPP_PIN_W-1:0] pins_s1_r;
    logic [FPP_PIN_W-1:0] pins_s2_r;
    logic                 a_clk_s3_r;
    logic                 b_clk_s3_r;
    logic                 a_clk;
    logic                 a_sel_n;
    logic                 a_en;
    logic                 a_wnr;
    logic                 a_mb;
    logic                 a_pg;
    logic [35:0]          a_din;
    logic                 b_clk;
    logic                 b_sel_n;
    logic                 b_en;
    logic                 b_wnr;
    logic                 b_pg;
    logic [1:0]           b_size_pin;
    logic                 b_endian_n;
    logic [1:0]           b_swap;
    logic [35:0]          b_din;
    logic                 odd;
    logic [1:0]           preset_pin;
    logic                 a_rise;
    logic                 b_rise;
    logic                 a_acc;
    logic                 b_acc;
    fpp_size_type         size_pend_r;
    fpp_size_type         size_act_r;
    logic                 endian_pend_r;
    logic                 endian_act_r;
    logic [35:0]          mail1_r;
    logic [35:0]          mail2_r;
    logic [35:0]          hold_r;
    logic [35:0]          chunk_r;
    logic [1:0]           phase_r;
    logic [1:0]           last_w;
    logic [35:0]          word_w;
    logic [35:0]          chunk_w;
    logic [3:0]           a_fail;
    logic [3:0]           b_fail;
    logic [3:0]           b_valid;
    logic                 a_force;
    logic                 b_force;
    logic                 b_err;
    logic                 a_err;
    logic [1:0]           full_cnt_r;
    logic [1:0]           rel_cnt_r;
    logic [3:0]           status_r;
    logic [3:0]           mask_r;
    logic                 par_en_r;
    logic [3:0]           events;
    logic [3:0]           clr_w;
    logic                 wr_pend_r;
    logic [7:0]           wr_addr_r;
    logic [31:0]          rd_mux;

    // every pin crosses two flip-flops before use
    assign pins_w = {port_a_clock, port_a_select_n, port_a_enable, port_a_write_not_read,
                     port_a_mailbox_sel, port_a_parity_gen, port_a_data_in,
                     port_b_clock, port_b_select_n, port_b_enable, port_b_write_not_read,
                     port_b_parity_gen, bus_size_sel1, bus_size_sel0, endian_select_n,
                     swap_sel1, swap_sel0, port_b_data_in,
                     odd_even_sel, offset_preset_sel1, offset_preset_sel0};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins_s1_r  <= '0;
            pins_s2_r  <= '0;
            a_clk_s3_r <= 1'b0;
            b_clk_s3_r <= 1'b0;
        end else begin
            pins_s1_r  <= pins_w;
            pins_s2_r  <= pins_s1_r;
            a_clk_s3_r <= a_clk;
            b_clk_s3_r <= b_clk;
        end
    end

    assign {a_clk, a_sel_n, a_en, a_wnr, a_mb, a_pg, a_din,
            b_clk, b_sel_n, b_en, b_wnr, b_pg, b_size_pin, b_endian_n,
            b_swap, b_din, odd, preset_pin} = pins_s2_r;

    // port clock edges and qualified accesses
    assign a_rise = a_clk & ~a_clk_s3_r;
    assign b_rise = b_clk & ~b_clk_s3_r;
    assign a_acc  = a_rise & ~a_sel_n & a_en;
    assign b_acc  = b_rise & ~b_sel_n & b_en;

    // bus size and endian: capture on one port B edge, apply on the next
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            size_pend_r   <= FPP_SIZE_LONG;
            size_act_r    <= FPP_SIZE_LONG;
            endian_pend_r <= 1'b0;
            endian_act_r  <= 1'b0;
        end else if (b_rise) begin
            size_pend_r   <= fpp_size_type'(b_size_pin);
            endian_pend_r <= b_endian_n;
            size_act_r    <= size_pend_r;
            endian_act_r  <= endian_pend_r;
        end
    end

    // mail-in register: port A writes, port B reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mail1_r        <= '0;
            mail_in_full_n <= 1'b1;
        end else begin
            if (b_acc && !b_wnr && size_act_r == FPP_SIZE_MAIL) begin
                mail_in_full_n <= 1'b1;
            end else if (a_acc && a_wnr && a_mb && mail_in_full_n) begin
                mail1_r        <= a_din;
                mail_in_full_n <= 1'b0;
            end
        end
    end

    // mail-out register: port B writes, port A reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mail2_r         <= '0;
            mail_out_full_n <= 1'b1;
        end else begin
            if (a_acc && !a_wnr && a_mb) begin
                mail_out_full_n <= 1'b1;
            end else if (b_acc && b_wnr && size_act_r == FPP_SIZE_MAIL && mail_out_full_n) begin
                mail2_r         <= b_din;
                mail_out_full_n <= 1'b0;
            end
        end
    end

    // swap of a long word at the start of a FIFO read
    function automatic logic [35:0] swap_word(input logic [35:0] w, input fpp_swap_type m);
        unique case (m)
            FPP_SWAP_NONE:  swap_word = w;
            FPP_SWAP_BYTE:  swap_word = {w[8:0], w[17:9], w[26:18], w[35:27]};
            FPP_SWAP_WORD:  swap_word = {w[17:0], w[35:18]};
            FPP_SWAP_BWORD: swap_word = {w[26:18], w[35:27], w[8:0], w[17:9]};
        endcase
    endfunction : swap_word

    // number of transfers per long word, less one
    always_comb begin
        unique case (size_act_r)
            FPP_SIZE_WORD: last_w = 2'h1;
            FPP_SIZE_BYTE: last_w = 2'h3;
            default:       last_w = 2'h0;
        endcase
    end

    // word of this transfer and its placement on the lanes
    always_comb begin
        logic [1:0] idx;
        idx     = 2'h0;
        word_w  = (phase_r == 2'h0) ? swap_word(fifo_word, fpp_swap_type'(b_swap)) : hold_r;
        chunk_w = word_w;
        if (size_act_r == FPP_SIZE_WORD) begin
            idx     = endian_act_r ? phase_r : 2'(2'h1 - phase_r);
            chunk_w = idx[0] ? {18'h0, word_w[35:18]} : {18'h0, word_w[17:0]};
            if (!endian_act_r) begin
                chunk_w = {chunk_w[17:0], 18'h0};
            end
        end else if (size_act_r == FPP_SIZE_BYTE) begin
            idx     = endian_act_r ? phase_r : 2'(2'h3 - phase_r);
            chunk_w = {27'h0, word_w[idx*FPP_LANE_W +: FPP_LANE_W]};
            if (!endian_act_r) begin
                chunk_w = {chunk_w[8:0], 27'h0};
            end
        end
    end

    // FIFO read sequencing on port B
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r         <= 2'h0;
            hold_r          <= '0;
            chunk_r         <= '0;
            fifo_word_taken <= 1'b0;
        end else begin
            fifo_word_taken <= 1'b0;
            if (b_acc && !b_wnr && size_act_r != FPP_SIZE_MAIL) begin
                chunk_r <= chunk_w;
                if (phase_r == 2'h0) begin
                    hold_r          <= word_w;
                    fifo_word_taken <= 1'b1;
                end
                phase_r <= (phase_r >= last_w) ? 2'h0 : 2'(phase_r + 2'h1);
            end
        end
    end

    // data outputs: enabled only for selected reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_data_out <= '0;
            port_a_data_oe  <= 1'b0;
            port_b_data_out <= '0;
            port_b_data_oe  <= 1'b0;
        end else begin
            port_a_data_oe  <= ~a_sel_n & ~a_wnr;
            port_a_data_out <= a_pg ? fpp_fill_parity(mail2_r, odd) : mail2_r;
            port_b_data_oe  <= ~b_sel_n & ~b_wnr;
            if (size_act_r == FPP_SIZE_MAIL) begin
                port_b_data_out <= b_pg ? fpp_fill_parity(mail1_r, odd) : mail1_r;
            end else begin
                port_b_data_out <= b_pg ? fpp_fill_parity(chunk_r, odd) : chunk_r;
            end
        end
    end

    // parity checking on both input buses
    fpp_parity_tree u_tree_a (
        .data      (a_din),
        .odd       (odd),
        .lane_fail (a_fail)
    );

    fpp_parity_tree u_tree_b (
        .data      (b_din),
        .odd       (odd),
        .lane_fail (b_fail)
    );

    // lanes used by the active port B size
    always_comb begin
        unique case (size_act_r)
            FPP_SIZE_WORD: b_valid = endian_act_r ? 4'h3 : 4'hC;
            FPP_SIZE_BYTE: b_valid = endian_act_r ? 4'h1 : 4'h8;
            default:       b_valid = 4'hF;
        endcase
    end

    assign b_force = ~b_sel_n & b_en & ~b_wnr & (b_size_pin == 2'h3) & b_pg;
    assign a_force = ~a_sel_n & a_en & ~a_wnr & a_mb & a_pg;
    assign b_err   = |(b_fail & b_valid);
    assign a_err   = |a_fail;

    // error flags, forced high during a mailbox read with parity generation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_parity_error_n <= 1'b1;
            port_b_parity_error_n <= 1'b1;
        end else begin
            port_a_parity_error_n <= a_force | ~par_en_r | ~a_err;
            port_b_parity_error_n <= b_force | ~par_en_r | ~b_err;
        end
    end

    // reset flags and the full flag release after two port A edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            full_cnt_r     <= 2'h0;
            full_flag_n    <= 1'b0;
            almost_full_n  <= 1'b1;
            almost_empty_n <= 1'b0;
            empty_flag_n   <= 1'b0;
        end else begin
            almost_full_n  <= 1'b1;
            almost_empty_n <= 1'b0;
            empty_flag_n   <= 1'b0;
            if (full_cnt_r == FPP_FULL_EDGES) begin
                full_flag_n <= 1'b1;
            end else if (a_rise) begin
                full_cnt_r <= 2'(full_cnt_r + 2'h1);
            end
        end
    end

    // offset preset caught once the synchroniser holds post-release pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rel_cnt_r     <= 2'h0;
            offset_preset <= 2'h0;
        end else begin
            if (rel_cnt_r != FPP_CAPTURE_END) begin
                rel_cnt_r <= 2'(rel_cnt_r + 2'h1);
            end
            if (rel_cnt_r == FPP_CAPTURE_CNT) begin
                offset_preset <= preset_pin;
            end
        end
    end

    // register read data
    always_comb begin
        unique case (haddr[7:0])
            FPP_STATUS_OFS: rd_mux = {28'h0, status_r};
            FPP_MASK_OFS:   rd_mux = {28'h0, mask_r};
            FPP_CTRL_OFS:   rd_mux = {31'h0, par_en_r};
            FPP_STATE_OFS:  rd_mux = {19'h0, offset_preset, endian_act_r, size_act_r,
                                      port_a_parity_error_n, port_b_parity_error_n,
                                      mail_out_full_n, mail_in_full_n, full_flag_n,
                                      almost_full_n, empty_flag_n, almost_empty_n};
            default:        rd_mux = 32'h0;
        endcase
    end

    // bus slave: zero wait states, always OKAY
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= hsel & htrans[1] & hwrite & (haddr[31:8] == 24'h0);
            wr_addr_r <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                hrdata <= (haddr[31:8] == 24'h0) ? rd_mux : 32'h0;
            end
        end
    end

    // register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_r   <= FPP_MASK_RST;
            par_en_r <= FPP_CTRL_RST;
        end else if (wr_pend_r) begin
            if (wr_addr_r == FPP_MASK_OFS) begin
                mask_r <= hwdata[3:0];
            end
            if (wr_addr_r == FPP_CTRL_OFS) begin
                par_en_r <= hwdata[FPP_CTRL_PAR_EN];
            end
        end
    end

    // sticky events; a set in the clearing cycle wins
    assign events[FPP_EV_PE_B]     = ~port_b_parity_error_n;
    assign events[FPP_EV_PE_A]     = ~port_a_parity_error_n;
    assign events[FPP_EV_MAIL_IN]  = ~mail_in_full_n;
    assign events[FPP_EV_MAIL_OUT] = ~mail_out_full_n;
    assign clr_w = (wr_pend_r && wr_addr_r == FPP_STATUS_OFS) ? hwdata[3:0] : 4'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= 4'h0;
            irq      <= 1'b0;
        end else begin
            status_r <= (status_r & ~clr_w) | events;
            irq      <= |(status_r & mask_r);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_b_forced;
        b_force |=> port_b_parity_error_n;
    endproperty
    a_b_forced: assert property (p_b_forced) else $error("port B error flag not forced");

    property p_b_error;
        (par_en_r && !b_force && b_err) |=> !port_b_parity_error_n;
    endproperty
    a_b_error: assert property (p_b_error) else $error("port B lane error missed");

    property p_a_float;
        a_wnr |=> !port_a_data_oe;
    endproperty
    a_a_float: assert property (p_a_float) else $error("port A drives during write");

    property p_b_float;
        b_wnr |=> !port_b_data_oe;
    endproperty
    a_b_float: assert property (p_b_float) else $error("port B drives during write");

    property p_size_apply;
        b_rise |=> size_act_r == $past(size_pend_r);
    endproperty
    a_size_apply: assert property (p_size_apply) else $error("bus size not applied");

    property p_mail_read;
        (b_acc && !b_wnr && size_act_r == FPP_SIZE_MAIL) |=> mail_in_full_n;
    endproperty
    a_mail_read: assert property (p_mail_read) else $error("mail-in flag not set");

    property p_a_gen;
        a_pg |=> port_a_data_out[35] == ((^$past(mail2_r[34:27])) ^ $past(odd));
    endproperty
    a_a_gen: assert property (p_a_gen) else $error("port A parity wrong");

    property p_reset_flags;
        (rel_cnt_r == 2'h0) |-> (almost_full_n && mail_out_full_n && !empty_flag_n
                                 && !almost_empty_n && !full_flag_n);
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong");
endmodule : fpp_port_ctrl

// *** fpp_far_end.sv ***
`timescale 1ns/10ps
// far side: free-running port clocks and the port A processor
module fpp_far_end (
    output logic        port_a_clock,
    output logic        port_b_clock,
    output logic        port_a_select_n,
    output logic        port_a_write_not_read,
    output logic [35:0] port_a_data_in
);
    // clocks unrelated in phase to clk
    initial begin
        {port_a_clock, port_b_clock} = 2'b00;
        {port_a_select_n, port_a_write_not_read} = 2'b11;
        port_a_data_in = 36'h0;
        #3;
        fork
            forever #40 port_a_clock = ~port_a_clock;
            forever #37 port_b_clock = ~port_b_clock;
        join
    end
    // one mailbox write or read; data lines show the inverse once released
    task automatic mail_a(input logic w, input logic [35:0] d);
        @(negedge port_a_clock);
        port_a_select_n = 1'b0;
        port_a_write_not_read = w;
        port_a_data_in = d;
        @(negedge port_a_clock);
        port_a_select_n = 1'b1;
        port_a_write_not_read = 1'b1;
        port_a_data_in = ~d;
    endtask : mail_a
endmodule : fpp_far_end

// *** fpp_port_ctrl_tb.sv ***
`timescale 1ns/10ps
module fpp_port_ctrl_tb;
    import fpp_pkg::*;
    logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, irq, fifo_word_taken;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, offset_preset;
    logic [2:0] hsize;
    logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, fifo_word;
    logic port_a_clock, port_b_clock, port_a_select_n, port_a_write_not_read, port_a_data_oe;
    logic port_a_enable, port_a_mailbox_sel, port_a_parity_gen, swap_sel0, swap_sel1;
    logic port_b_select_n, port_b_enable, port_b_write_not_read, port_b_parity_gen;
    logic bus_size_sel0, bus_size_sel1, endian_select_n, odd_even_sel, port_b_data_oe;
    logic offset_preset_sel0, offset_preset_sel1, port_a_parity_error_n, port_b_parity_error_n;
    logic almost_full_n, almost_empty_n, empty_flag_n, full_flag_n, mail_in_full_n;
    logic mail_out_full_n;
    int   err_total, compares;
    int   taken = 0;
    // size, odd, expected error flag, port B word
    localparam logic [39:0] TAB [6] = '{40'h20_0000_0000, 40'h38_0402_0100, 40'h08_0402_0100,
        40'hB8_0000_0000, 40'h88_0000_0000, 40'h38_0402_0100};
    assign hready = hreadyout;
    fpp_port_ctrl u_dut (.*);
    fpp_far_end u_far (.*);
    // long words taken from the FIFO head
    always @(posedge clk) if (fifo_word_taken) taken <= taken + 1;
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            conclude();
        end
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk("resp", 1'b0, hresp);
    endtask : ahb
    task automatic settle;
        repeat (80) @(posedge clk);
    endtask : settle
    function automatic logic [35:0] fill(input logic [35:0] d, input logic odd);
        fill = d;
        for (int i = 0; i < FPP_LANES; i++) begin
            fill[i*FPP_LANE_W+8] = ^d[i*FPP_LANE_W +: 8] ^ odd;
        end
    endfunction : fill
    // main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, nrst, err_total, compares} = '0;
        {hsize, fifo_word, port_b_data_in} = {3'h2, 36'h1_0203_0405, 36'h5_A5A5_A5A5};
        {port_a_enable, port_a_mailbox_sel, port_a_parity_gen, swap_sel0, swap_sel1} = 5'b11000;
        {port_b_select_n, port_b_enable, port_b_write_not_read, port_b_parity_gen} = 4'b1110;
        {bus_size_sel1, bus_size_sel0, endian_select_n, odd_even_sel} = 4'b0001;
        {offset_preset_sel1, offset_preset_sel0} = 2'b10;
        repeat (3) @(posedge clk);
        chk("flags", 6'b111000, {almost_full_n, mail_in_full_n, mail_out_full_n,
            empty_flag_n, almost_empty_n, full_flag_n});
        @(posedge clk);
        nrst <= 1'b1;
        settle();
        chk("preset", 2'h2, offset_preset);
        chk("full", 1'b1, full_flag_n);
        ahb(1'b0, FPP_CTRL_OFS, 32'h0);
        chk("ctrl", 36'h1, q);
        ahb(1'b0, FPP_MASK_OFS, 32'h0);
        chk("mask", 36'h0, q);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 36'h0, q);
        for (int o = 1; o >= 0; o--) begin
            odd_even_sel <= o[0];
            u_far.mail_a(1'b1, 36'h9_1234_5678 ^ o);
            @(posedge clk);
            settle();
            chk("mail_in", 1'b0, mail_in_full_n);
            chk("oe_a", 1'b0, port_a_data_oe);
            {port_b_select_n, port_b_write_not_read, port_b_parity_gen} <= 3'b001;
            {bus_size_sel1, bus_size_sel0} <= 2'b11;
            settle();
            chk("mail_in", 1'b1, mail_in_full_n);
            chk("pe_b", 1'b1, port_b_parity_error_n);
            chk("oe_b", 1'b1, port_b_data_oe);
            chk("data_b", fill(36'h9_1234_5678 ^ o, o[0]), port_b_data_out);
            {port_b_write_not_read, port_b_parity_gen} <= 2'b10;
            settle();
            chk("oe_b", 1'b0, port_b_data_oe);
            chk("mail_out", 1'b0, mail_out_full_n);
        end
        // port A reads the mail-out word with parity generation
        port_b_select_n <= 1'b1;
        port_a_parity_gen <= 1'b1;
        u_far.mail_a(1'b0, 36'h0);
        settle();
        chk("mail_out", 1'b1, mail_out_full_n);
        chk("data_a", fill(36'h5_A5A5_A5A5, 1'b0), port_a_data_out);
        chk("pe_a", 1'b0, port_a_parity_error_n);
        foreach (TAB[i]) begin
            {bus_size_sel1, bus_size_sel0, odd_even_sel} <= TAB[i][39:37];
            port_b_data_in <= TAB[i][35:0];
            settle();
            chk("pe_b", TAB[i][36], port_b_parity_error_n);
        end
        // byte-size FIFO reads, endian high, byte swap: four reads per long word
        {bus_size_sel1, bus_size_sel0, endian_select_n, swap_sel0} <= 4'b1011;
        port_b_write_not_read <= 1'b0;
        settle();
        q = taken;
        for (int k = 0; k < 4; k++) begin
            @(negedge port_b_clock);
            @(posedge clk) port_b_select_n <= 1'b0;
            @(negedge port_b_clock);
            @(posedge clk) port_b_select_n <= 1'b1;
            settle();
            chk("fifo_b", {27'h0, fifo_word[27-9*k +: 9]}, port_b_data_out);
        end
        chk("taken", q + 1, taken);
        ahb(1'b0, FPP_STATUS_OFS, 32'h0);
        chk("status", 36'h1, q & 32'h1);
        chk("irq", 1'b0, irq);
        ahb(1'b1, FPP_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", 1'b1, irq);
        ahb(1'b1, FPP_STATUS_OFS, 32'h1);
        ahb(1'b0, FPP_STATUS_OFS, 32'h0);
        chk("status", 36'h0, q & 32'h1);
        chk("irq", 1'b0, irq);
        conclude();
    end
endmodule : fpp_port_ctrl_tb
